// file: logic/msrc_checker.sv
/*
  Request checker for a serial-line bus slave with a holding-register map.
  Assumes a framer that delivers one decoded request per pulse and a store
  holding the register contents; section lengths are parameters, section starts and address limits are msrc_pkg constants.
*/
`timescale 1ns/1ps
module msrc_checker #(
  parameter logic [15:0] SECT_LEN_0 = 16'h0006,
  parameter logic [15:0] SECT_LEN_1 = 16'h000A,
  parameter logic [15:0] SECT_LEN_2 = 16'h0004,
  parameter logic [15:0] SECT_LEN_3 = 16'h0012,
  parameter logic [15:0] SECT_LEN_4 = 16'h0006,
  parameter logic [15:0] SECT_LEN_5 = 16'h0040,
  parameter logic [15:0] SECT_LEN_6 = 16'h0040,
  parameter logic [15:0] SECT_LEN_7 = 16'h0040,
  parameter logic [7:0]  SECT_RO    = 8'h0A
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic                req_valid_i,
  input  wire msrc_pkg::msrc_req_s req_i,
  output logic                     rsp_valid_o,
  output msrc_pkg::msrc_rsp_s      rsp_o,
  output logic                     wr_ok_o
);

  // ---------------------------------------------------------------------------
  // Map lookup
  // ---------------------------------------------------------------------------
  localparam int NUM_SECT = msrc_pkg::NUM_SECT;
  localparam logic [15:0] SECT_START [NUM_SECT] = '{
    msrc_pkg::SECT_PASSWORD, msrc_pkg::SECT_REALTIME, msrc_pkg::SECT_LOGMEM,
    msrc_pkg::SECT_INFO, msrc_pkg::SECT_DISPLAY, msrc_pkg::SECT_USER,
    msrc_pkg::SECT_FACTORY, msrc_pkg::SECT_LOGITEMS};
  localparam logic [15:0] SECT_LEN [NUM_SECT] = '{
    SECT_LEN_0, SECT_LEN_1, SECT_LEN_2, SECT_LEN_3,
    SECT_LEN_4, SECT_LEN_5, SECT_LEN_6, SECT_LEN_7};

  // Section index holding a register, or NUM_SECT for a hole
  function automatic logic [3:0] sect_of(input logic [16:0] reg_n);
    logic [3:0] idx;
    idx = 4'(NUM_SECT);
    for (int s = 0; s < NUM_SECT; s++) begin
      if (reg_n >= {1'b0, SECT_START[s]} &&
          reg_n < {1'b0, SECT_START[s]} + {1'b0, SECT_LEN[s]}) begin
        idx = 4'(s);
      end
    end
    return idx;
  endfunction : sect_of

  // ---------------------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------------------
  wire logic [16:0] first_reg  = {1'b0, req_i.addr} + 17'h00001;
  wire logic [16:0] last_reg   = first_reg + {1'b0, req_i.qty} - 17'h00001;
  wire logic [16:0] last_addr  = {1'b0, req_i.addr} + {1'b0, req_i.qty} - 17'h00001;
  wire logic [3:0]  sect_first = sect_of(first_reg);
  wire logic [3:0]  sect_last  = sect_of(last_reg);

  // Items are two-register words starting at even register numbers
  wire logic first_on_item = ~first_reg[0];
  wire logic last_on_item  = last_reg[0];
  wire logic one_section   = (sect_first == sect_last);
  wire logic no_hole       = (sect_first != 4'(NUM_SECT)) && one_section;
  wire logic qty_zero      = (req_i.qty < msrc_pkg::QTY_MIN);

  wire logic [16:0] rd_bytes = {req_i.qty, 1'b0} + {1'b0, msrc_pkg::RD_HDR_BYTES};
  wire logic [16:0] wr_bytes = {1'b0, 8'h00, req_i.byte_cnt} + {1'b0, msrc_pkg::WR_HDR_BYTES};

  wire logic rd_qty_bad  = qty_zero || (req_i.qty > msrc_pkg::QTY_MAX_RD);
  wire logic rd_size_bad = rd_bytes > {1'b0, msrc_pkg::MAX_PDU};
  wire logic rd_lim_bad  = last_addr > msrc_pkg::RD_ADDR_LIM;
  wire logic rd_hole_bad = ~no_hole;
  wire logic rd_end_bad  = ~last_on_item;

  wire logic wr_size_bad = wr_bytes > {1'b0, msrc_pkg::MAX_PDU} || qty_zero ||
                           ({1'b0, 8'h00, req_i.byte_cnt} != {req_i.qty, 1'b0});
  wire logic wr_lim_bad  = last_addr > msrc_pkg::WR_ADDR_LIM;
  wire logic wr_hole_bad = ~no_hole;
  wire logic wr_start_bad = ~first_on_item;
  wire logic wr_ro_bad   = no_hole && SECT_RO[sect_first[2:0]];

  // Read exception; value check ranks above address checks
  wire logic [7:0] rd_exc =
      rd_qty_bad ? msrc_pkg::EXC_ILL_VAL :
      (rd_size_bad || rd_lim_bad || rd_hole_bad || rd_end_bad) ?
      msrc_pkg::EXC_ILL_ADDR : msrc_pkg::EXC_NONE;

  wire logic [7:0] wr_exc =
      (wr_size_bad || wr_lim_bad || wr_hole_bad || wr_start_bad ||
       ~last_on_item || wr_ro_bad) ?
      msrc_pkg::EXC_ILL_ADDR : msrc_pkg::EXC_NONE;

  wire logic is_rd = (req_i.func == msrc_pkg::FC_READ_HOLD);
  wire logic is_wr = (req_i.func == msrc_pkg::FC_WRITE_MULT);
  wire logic is_id = (req_i.func == msrc_pkg::FC_REPORT_ID);

  wire logic [7:0] exc_sel =
      is_rd ? rd_exc :
      is_wr ? wr_exc :
      is_id ? msrc_pkg::EXC_NONE :
      msrc_pkg::EXC_ILL_FUNC;

  msrc_pkg::msrc_rsp_s rsp_d;
  assign rsp_d.is_exc    = (exc_sel != msrc_pkg::EXC_NONE);
  assign rsp_d.func      = req_i.func;
  assign rsp_d.exc_code  = exc_sel;
  assign rsp_d.do_id     = is_id;
  assign rsp_d.first_reg = first_reg[15:0];
  assign rsp_d.qty       = req_i.qty;

  // Write is released to the store only when clean; no value check
  wire logic wr_ok_d = req_valid_i && is_wr && (wr_exc == msrc_pkg::EXC_NONE);

  // ---------------------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_o       <= '0;
      wr_ok_o     <= 1'b0;
    end else begin
      rsp_valid_o <= req_valid_i;
      wr_ok_o     <= wr_ok_d;
      if (req_valid_i) begin
        rsp_o <= rsp_d;
      end
    end
  end

endmodule : msrc_checker

// file: common/msrc_pkg.sv
/*
  Constants and carrier types for the holding-register request checker.
  Assumes a framer upstream that has already checked address and CRC.
*/
package msrc_pkg;

  // ---------------------------------------------------------------------------
  // Function and exception codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FC_READ_HOLD  = 8'h03;
  localparam logic [7:0] FC_WRITE_MULT = 8'h10;
  localparam logic [7:0] FC_REPORT_ID  = 8'h11;
  localparam logic [7:0] EXC_NONE      = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0] EXC_ILL_VAL   = 8'h03;

  // ---------------------------------------------------------------------------
  // Limits
  // ---------------------------------------------------------------------------
  localparam logic [15:0] QTY_MIN      = 16'h0001;
  localparam logic [15:0] QTY_MAX_RD   = 16'h007D;
  localparam logic [15:0] MAX_PDU      = 16'h00FD;
  localparam logic [15:0] RD_HDR_BYTES = 16'h0002;
  localparam logic [15:0] WR_HDR_BYTES = 16'h0006;
  localparam logic [16:0] RD_ADDR_LIM  = 17'h00FFF;
  localparam logic [16:0] WR_ADDR_LIM  = 17'h0FFFF;

  // ---------------------------------------------------------------------------
  // Section starts, one-based register numbers
  // ---------------------------------------------------------------------------
  localparam int          NUM_SECT = 8;
  localparam logic [15:0] SECT_PASSWORD = 16'h0002;
  localparam logic [15:0] SECT_REALTIME = 16'h0064;
  localparam logic [15:0] SECT_LOGMEM   = 16'h00C8;
  localparam logic [15:0] SECT_INFO     = 16'h03E8;
  localparam logic [15:0] SECT_DISPLAY  = 16'h05DC;
  localparam logic [15:0] SECT_USER     = 16'h07D0;
  localparam logic [15:0] SECT_FACTORY  = 16'h0FA0;
  localparam logic [15:0] SECT_LOGITEMS = 16'h2710;

  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [7:0]  byte_cnt;
  } msrc_req_s;

  typedef struct packed {
    logic        is_exc;
    logic [7:0]  func;
    logic [7:0]  exc_code;
    logic        do_id;
    logic [15:0] first_reg;
    logic [15:0] qty;
  } msrc_rsp_s;

endpackage : msrc_pkg

// file: testbench/msrc_master.sv
/* Bus master model issuing decoded requests.
   Assumes the bench samples the reply at the falling edge after send. */
`timescale 1ns/1ps
module msrc_master (
  input  wire logic           clk_i,
  output logic                req_valid_o,
  output msrc_pkg::msrc_req_s req_o
);
  initial begin
    req_valid_o = 1'b0;
    req_o       = '0;
  end
  task automatic send(input logic [7:0] func, input logic [15:0] reg_no, input logic [15:0] qty);
    @(negedge clk_i);
    req_valid_o = 1'b1;
    req_o       = '{func, reg_no - 16'h0001, qty, 8'(qty * 2)};
    @(negedge clk_i);
    req_valid_o = 1'b0;
    req_o       = ~req_o;
  endtask : send
endmodule : msrc_master

// file: testbench/msrc_checker_asserts.sv
/* Port checks for the request checker.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module msrc_checker_asserts (
  input wire logic                clk_i,
  input wire logic                srst_i,
  input wire logic                req_valid_i,
  input wire msrc_pkg::msrc_req_s req_i,
  input wire logic                rsp_valid_o,
  input wire msrc_pkg::msrc_rsp_s rsp_o,
  input wire logic                wr_ok_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [16:0] last;
  logic        rd;
  logic        wr;
  logic        qok;
  assign last = {1'b0, req_i.addr} + {1'b0, req_i.qty} - 17'h00001;
  assign rd   = req_valid_i && req_i.func == msrc_pkg::FC_READ_HOLD;
  assign wr   = req_valid_i && req_i.func == msrc_pkg::FC_WRITE_MULT && req_i.qty != 16'h0000;
  assign qok  = req_i.qty >= msrc_pkg::QTY_MIN && req_i.qty <= msrc_pkg::QTY_MAX_RD;
  sequence s_exc(logic [7:0] code);
    rsp_valid_o && rsp_o.is_exc && rsp_o.exc_code == code && !wr_ok_o;
  endsequence
  AST_LAT: assert property (req_valid_i |=> rsp_valid_o)
    else $error("no reply");
  AST_IDLE: assert property (!req_valid_i |=> !rsp_valid_o && !wr_ok_o && $stable(rsp_o))
    else $error("reply without request");
  AST_FUNC: assert property (req_valid_i && !(req_i.func inside {8'h03, 8'h10, 8'h11}) |=> s_exc(8'h01))
    else $error("bad function accepted");
  AST_ID: assert property (req_valid_i && req_i.func == 8'h11 |=> rsp_o.do_id && !rsp_o.is_exc)
    else $error("id reply wrong");
  AST_QTY: assert property (rd && !qok |=> s_exc(8'h03))
    else $error("read count not refused");
  AST_RLIM: assert property (rd && qok && last > msrc_pkg::RD_ADDR_LIM |=> s_exc(8'h02))
    else $error("read limit not refused");
  AST_HALF: assert property ((rd && qok || wr) && last[0] |=> s_exc(8'h02))
    else $error("half item not refused");
  AST_START: assert property (wr && !req_i.addr[0] |=> s_exc(8'h02))
    else $error("odd write start accepted");
  AST_WLIM: assert property (wr && last > msrc_pkg::WR_ADDR_LIM |=> s_exc(8'h02))
    else $error("write limit not refused");
  AST_WROK: assert property (wr_ok_o |-> rsp_valid_o && !rsp_o.is_exc && rsp_o.func == 8'h10)
    else $error("commit on bad write");
  AST_FIRST: assert property (rd ##1 !rsp_o.is_exc |-> rsp_o.first_reg == $past(req_i.addr) + 16'h0001)
    else $error("first register wrong");
endmodule : msrc_checker_asserts

// file: testbench/msrc_checker_tb.sv
/* Self-checking bench for the request checker.
   Assumes default map parameters and the master model. */
`timescale 1ns/1ps
module msrc_checker_tb;
  localparam logic [7:0] RD = 8'h03;
  localparam logic [7:0] WR = 8'h10;
  logic                clk_i;
  logic                srst_i;
  logic                req_valid;
  logic                rsp_valid;
  logic                wr_ok;
  msrc_pkg::msrc_req_s req;
  msrc_pkg::msrc_rsp_s rsp;
  int                  n_errors = 0;
  int                  n_tests  = 0;
  msrc_master msrc_master_i (.clk_i(clk_i), .req_valid_o(req_valid), .req_o(req));
  msrc_checker msrc_checker_i (.clk_i(clk_i), .srst_i(srst_i), .req_valid_i(req_valid), .req_i(req),
    .rsp_valid_o(rsp_valid), .rsp_o(rsp), .wr_ok_o(wr_ok));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic [7:0] f, input logic [15:0] r, input logic [15:0] q, input logic [7:0] c);
    msrc_master_i.send(f, r, q);
    check("rsp_valid", 16'(rsp_valid), 16'h0001);
    check("exc_code", 16'(rsp.exc_code), 16'(c));
    check("is_exc", 16'(rsp.is_exc), 16'(c != 8'h00));
    check("wr_ok", 16'(wr_ok), 16'(f == WR && c == 8'h00));
    check("func", 16'(rsp.func), 16'(f));
    check("qty", rsp.qty, q);
  endtask : xfer
  task automatic test_read;
    xfer(RD, 16'h0002, 16'h0002, 8'h00);
    check("first_reg", rsp.first_reg, 16'h0002);
    xfer(RD, 16'h0003, 16'h0001, 8'h00);
    xfer(RD, 16'h0FA0, 16'h0002, 8'h00);
    xfer(RD, 16'h0002, 16'h0000, 8'h03);
    xfer(RD, 16'h0002, 16'h007E, 8'h03);
    xfer(RD, 16'h0002, 16'h007D, 8'h02);
    xfer(RD, 16'h0002, 16'h0001, 8'h02);
    xfer(RD, 16'h0008, 16'h0002, 8'h02);
    xfer(RD, 16'h2710, 16'h0002, 8'h02);
    $display("test_read done");
  endtask : test_read
  task automatic test_write;
    xfer(WR, 16'h0002, 16'h0002, 8'h00);
    xfer(WR, 16'h07D0, 16'h0002, 8'h00);
    xfer(WR, 16'h0003, 16'h0002, 8'h02);
    xfer(WR, 16'h0002, 16'h0001, 8'h02);
    xfer(WR, 16'h0064, 16'h0002, 8'h02);
    xfer(WR, 16'h0008, 16'h0002, 8'h02);
    xfer(WR, 16'h07D0, 16'h007C, 8'h02);
    xfer(WR, 16'h0000, 16'h0002, 8'h02);
    $display("test_write done");
  endtask : test_write
  task automatic test_misc;
    logic [7:0] bad [5] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h0F};
    xfer(8'h11, 16'h0001, 16'h0000, 8'h00);
    check("do_id", 16'(rsp.do_id), 16'h0001);
    foreach (bad[i]) xfer(bad[i], 16'h0002, 16'h0002, 8'h01);
    $display("test_misc done");
  endtask : test_misc
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    srst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    srst_i = 1'b0;
    check("rst_valid", 16'(rsp_valid), 16'h0000);
    test_read();
    test_write();
    test_misc();
    give_verdict();
  end
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule : msrc_checker_tb
bind msrc_checker msrc_checker_asserts msrc_checker_asserts_i (.clk_i(clk_i), .srst_i(srst_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .wr_ok_o(wr_ok_o));
